/* hdl/dpt_pkg.sv */
// constants and types shared by the dram packet transaction core
package dpt_pkg;

  // ==========================================================================
  // geometry
  localparam int BANKS     = 8;
  localparam int BANK_W    = 3;
  localparam int ROWS      = 2;
  localparam int ROW_W     = 1;
  localparam int COLS      = 2;
  localparam int COL_W     = 1;
  localparam int REQ_W     = 12;
  localparam int DQ_W      = 16;
  localparam int WORDS     = 16;
  localparam int PKT_W     = 256;
  localparam int PEND      = 4;
  localparam int AGE_W     = 4;
  localparam int BITS_PER_CYCLE = 8;

  // ==========================================================================
  // request packet layout: first word in bits 23:12, second in 11:0
  localparam int OP_LSB    = 21;
  localparam int BANK_LSB  = 18;
  localparam logic [2:0] OP_NOP       = 3'h0;
  localparam logic [2:0] OP_ACTIVATE  = 3'h1;
  localparam logic [2:0] OP_WRITE     = 3'h2;
  localparam logic [2:0] OP_READ      = 3'h3;
  localparam logic [2:0] OP_PRECHARGE = 3'h4;

  // ==========================================================================
  // timing in whole link clock cycles
  localparam logic [3:0] WRITE_DATA_DELAY            = 4'h3;
  localparam logic [3:0] COLUMN_ACCESS_LATENCY       = 4'h6;
  localparam logic [3:0] ACTIVATE_TO_WRITE_DELAY     = 4'h1;
  localparam logic [3:0] ACTIVATE_TO_READ_DELAY      = 4'h5;
  localparam logic [3:0] COLUMN_CYCLE_INTERVAL       = 4'h2;
  localparam logic [3:0] WRITE_TO_PRECHARGE_INTERVAL = 4'ha;
  localparam logic [3:0] READ_TO_PRECHARGE_INTERVAL  = 4'h6;
  localparam logic [3:0] AGE_MAX                     = 4'hf;
  localparam logic [3:0] LAST_WORD                   = 4'hf;

  typedef enum logic [1:0] {XFER_IDLE, XFER_WRITE, XFER_READ} dpt_xfer_type;

endpackage

/* hdl/dpt_core.sv */
// device side transaction logic of an eight bank packet dram
// What this block does
// - request packet spans eight bit windows, one link cycle
// - data packet spans sixteen bit windows
// - activate loads row into sense amps
// - write takes data after write delay
// - read drives data after access latency
// - precharge closes the bank's open row
// - sixteen data bits per system clock cycle
// - eight banks, four interleaved transactions
// - two 12-bit words form one request
// - column access only while bank open
// - request and negative lines are inverted
`timescale 1ns/100ps
`default_nettype none

module dpt_core
(
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_master_clock_pos,
  input  wire logic        i_master_clock_neg,
  input  wire logic [11:0] i_request_bus,
  input  wire logic [15:0] i_data_bus_pos,
  output logic      [15:0] o_data_bus_pos,
  output logic             o_data_bus_pos_oe,
  output logic      [15:0] o_data_bus_neg,
  output logic             o_data_bus_neg_oe,
  output logic             o_protocol_error
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [1:0]                                    clkp_sync;
    logic [1:0]                                    clkn_sync;
    logic                                          clk_prev;
    logic [1:0][11:0]                              rq_sync;
    logic [1:0][15:0]                              dq_sync;
    logic [11:0]                                   rq_first;
    logic [7:0]                                    bank_open;
    logic [7:0][dpt_pkg::ROW_W-1:0]                open_row;
    logic [7:0][3:0]                               age_act;
    logic [7:0][3:0]                               age_col;
    logic [7:0]                                    col_was_wr;
    logic [3:0]                                    age_any_col;
    logic                                          any_col_seen;
    logic [3:0]                                    pend_vld;
    logic [3:0]                                    pend_rd;
    logic [3:0][2:0]                               pend_bank;
    logic [3:0][dpt_pkg::COL_W-1:0]                pend_col;
    logic [3:0][3:0]                               pend_cnt;
    dpt_pkg::dpt_xfer_type                         xfer;
    logic [3:0]                                    idx;
    logic [2:0]                                    xbank;
    logic [dpt_pkg::COL_W-1:0]                     xcol;
    logic [15:0][15:0]                             pkt;
    logic [15:0]                                   dq_out;
    logic                                          dq_oe;
    logic                                          err;
    logic [7:0][dpt_pkg::COLS-1:0][255:0]          sense;
    logic [7:0][dpt_pkg::ROWS-1:0][dpt_pkg::COLS-1:0][255:0] core;
  } dpt_state_type;

  dpt_state_type r_ff;
  dpt_state_type nxt_r;

  // saturating age counter, so old events never wrap into fresh ones
  function automatic logic [3:0] sat_inc(input logic [3:0] v);
    sat_inc = (v == dpt_pkg::AGE_MAX) ? v : v + 4'h1;
  endfunction

  // ==========================================================================
  // next state
  always_comb
  begin
    logic        clk_lvl;
    logic        rise;
    logic        fall;
    logic [11:0] rq_now;
    logic [23:0] req;
    logic [2:0]  op;
    logic [2:0]  bank;
    logic        bad;
    logic        placed;
    logic [3:0]  need;
    clk_lvl = 1'b0;
    rise    = 1'b0;
    fall    = 1'b0;
    rq_now  = 12'h000;
    req     = 24'h000000;
    op      = 3'h0;
    bank    = 3'h0;
    bad     = 1'b0;
    placed  = 1'b0;
    need    = 4'h0;
    nxt_r     = r_ff;
    nxt_r.err = 1'b0;

    // two flop synchronisers for everything from the pins
    nxt_r.clkp_sync = {r_ff.clkp_sync[0], i_master_clock_pos};
    nxt_r.clkn_sync = {r_ff.clkn_sync[0], i_master_clock_neg};
    nxt_r.rq_sync   = {r_ff.rq_sync[0], i_request_bus};
    nxt_r.dq_sync   = {r_ff.dq_sync[0], i_data_bus_pos};

    // negative clock is low-true, so a high level there means clock low
    clk_lvl = r_ff.clkp_sync[1] & ~r_ff.clkn_sync[1];
    rq_now  = ~r_ff.rq_sync[1];
    rise    = clk_lvl & ~r_ff.clk_prev;
    fall    = ~clk_lvl & r_ff.clk_prev;
    nxt_r.clk_prev = clk_lvl;

    // data transfer engine, one bit window per system clock
    case (r_ff.xfer)
      dpt_pkg::XFER_WRITE:
      begin
        nxt_r.pkt[r_ff.idx] = r_ff.dq_sync[1];
        nxt_r.idx = r_ff.idx + 4'h1;
        if (r_ff.idx == dpt_pkg::LAST_WORD)
        begin
          nxt_r.sense[r_ff.xbank][r_ff.xcol] = nxt_r.pkt;
          nxt_r.xfer = dpt_pkg::XFER_IDLE;
        end
      end
      dpt_pkg::XFER_READ:
      begin
        nxt_r.dq_out = r_ff.pkt[r_ff.idx];
        nxt_r.idx = r_ff.idx + 4'h1;
        if (r_ff.idx == dpt_pkg::LAST_WORD)
          nxt_r.xfer = dpt_pkg::XFER_IDLE;
      end
      default:
      begin
        nxt_r.dq_oe = 1'b0;
      end
    endcase

    // link rising edge: first request word, ages, due data packets
    if (rise)
    begin
      nxt_r.rq_first    = rq_now;
      nxt_r.age_any_col = sat_inc(r_ff.age_any_col);
      for (int b = 0; b < dpt_pkg::BANKS; b++)
      begin
        nxt_r.age_act[b] = sat_inc(r_ff.age_act[b]);
        nxt_r.age_col[b] = sat_inc(r_ff.age_col[b]);
      end
      for (int p = 0; p < dpt_pkg::PEND; p++)
      begin
        if (r_ff.pend_vld[p])
        begin
          nxt_r.pend_cnt[p] = r_ff.pend_cnt[p] - 4'h1;
          if (r_ff.pend_cnt[p] == 4'h1)
          begin
            // the window that opens at this edge is word 0
            nxt_r.pend_vld[p] = 1'b0;
            nxt_r.xbank = r_ff.pend_bank[p];
            nxt_r.xcol  = r_ff.pend_col[p];
            nxt_r.idx   = 4'h1;
            if (r_ff.pend_rd[p])
            begin
              nxt_r.pkt    = r_ff.sense[r_ff.pend_bank[p]][r_ff.pend_col[p]];
              nxt_r.dq_out = nxt_r.pkt[0];
              nxt_r.dq_oe  = 1'b1;
              nxt_r.xfer   = dpt_pkg::XFER_READ;
            end
            else
            begin
              nxt_r.pkt[0] = r_ff.dq_sync[1];
              nxt_r.xfer   = dpt_pkg::XFER_WRITE;
            end
          end
        end
      end
    end

    // link falling edge: second word completes and decodes the request
    if (fall)
    begin
      req  = {r_ff.rq_first, rq_now};
      op   = req[dpt_pkg::OP_LSB +: 3];
      bank = req[dpt_pkg::BANK_LSB +: dpt_pkg::BANK_W];
      case (op)
        dpt_pkg::OP_ACTIVATE:
        begin
          bad = r_ff.bank_open[bank];
          if (!bad)
          begin
            nxt_r.bank_open[bank] = 1'b1;
            nxt_r.open_row[bank]  = req[dpt_pkg::ROW_W-1:0];
            nxt_r.sense[bank]     = r_ff.core[bank][req[dpt_pkg::ROW_W-1:0]];
            nxt_r.age_act[bank]   = 4'h0;
            nxt_r.age_col[bank]   = dpt_pkg::AGE_MAX;
          end
        end
        dpt_pkg::OP_WRITE, dpt_pkg::OP_READ:
        begin
          need = (op == dpt_pkg::OP_READ) ? dpt_pkg::ACTIVATE_TO_READ_DELAY
                                          : dpt_pkg::ACTIVATE_TO_WRITE_DELAY;
          bad  = !r_ff.bank_open[bank];
          if (r_ff.age_act[bank] < need)
            bad = 1'b1;
          if (r_ff.any_col_seen && r_ff.age_any_col < dpt_pkg::COLUMN_CYCLE_INTERVAL)
            bad = 1'b1;
          // four pending slots give four interleaved transactions
          for (int p = 0; p < dpt_pkg::PEND; p++)
          begin
            if (!bad && !placed && !r_ff.pend_vld[p])
            begin
              placed = 1'b1;
              nxt_r.pend_vld[p]  = 1'b1;
              nxt_r.pend_rd[p]   = (op == dpt_pkg::OP_READ);
              nxt_r.pend_bank[p] = bank;
              nxt_r.pend_col[p]  = req[dpt_pkg::COL_W-1:0];
              nxt_r.pend_cnt[p]  = (op == dpt_pkg::OP_READ) ? dpt_pkg::COLUMN_ACCESS_LATENCY
                                                            : dpt_pkg::WRITE_DATA_DELAY;
            end
          end
          if (!placed)
            bad = 1'b1;
          else
          begin
            nxt_r.age_col[bank]    = 4'h0;
            nxt_r.col_was_wr[bank] = (op == dpt_pkg::OP_WRITE);
            nxt_r.age_any_col      = 4'h0;
            nxt_r.any_col_seen     = 1'b1;
          end
        end
        dpt_pkg::OP_PRECHARGE:
        begin
          need = r_ff.col_was_wr[bank] ? dpt_pkg::WRITE_TO_PRECHARGE_INTERVAL
                                       : dpt_pkg::READ_TO_PRECHARGE_INTERVAL;
          bad  = r_ff.bank_open[bank] && (r_ff.age_col[bank] < need);
          if (r_ff.bank_open[bank] && !bad)
          begin
            // write the open row back and close it
            nxt_r.core[bank][r_ff.open_row[bank]] = r_ff.sense[bank];
            nxt_r.bank_open[bank] = 1'b0;
          end
        end
        default:
        begin
          bad = 1'b0;
        end
      endcase
      nxt_r.err = bad;
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      r_ff <= '0;
    else
      r_ff <= nxt_r;
  end

  // ==========================================================================
  // pins: negative data line carries the complement voltage
  assign o_data_bus_pos    = r_ff.dq_out;
  assign o_data_bus_pos_oe = r_ff.dq_oe;
  assign o_data_bus_neg    = ~r_ff.dq_out;
  assign o_data_bus_neg_oe = r_ff.dq_oe;
  assign o_protocol_error  = r_ff.err;

endmodule

`default_nettype wire

/* tb/dpt_core_monitor.sv */
// assertion checker watching the packet core's pins
`timescale 1ns/100ps
`default_nettype none
module dpt_core_monitor
(
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic        i_master_clock_pos,
  input wire logic        i_master_clock_neg,
  input wire logic [11:0] i_request_bus,
  input wire logic [15:0] i_data_bus_pos,
  input wire logic [15:0] o_data_bus_pos,
  input wire logic        o_data_bus_pos_oe,
  input wire logic [15:0] o_data_bus_neg,
  input wire logic        o_data_bus_neg_oe,
  input wire logic        o_protocol_error
);
  logic            link_ff;
  logic [11:0]     word_ff;
  logic [3:0]      age_ff;
  logic [3:0]      beat_ff;
  wire logic       fall = link_ff & ~i_master_clock_pos;
  wire logic [2:0] op   = word_ff[11:9];
  // ========
  // helpers: raw link edges, first word, age since a fall, beats
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      link_ff <= 1'b0;
      word_ff <= 12'h000;
      age_ff  <= 4'hf;
      beat_ff <= 4'h0;
    end
    else
    begin
      link_ff <= i_master_clock_pos;
      if (!link_ff && i_master_clock_pos)
        word_ff <= ~i_request_bus; // pins carry inverted levels
      age_ff  <= fall ? 4'h0 : (age_ff == 4'hf ? age_ff : age_ff + 4'h1);
      beat_ff <= o_data_bus_pos_oe ? beat_ff + 4'h1 : 4'h0;
    end
  end
  // ========
  // properties; windows allow one cycle of slack in the synchronisers
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence seq_refused;
    ##[2:5] o_protocol_error;
  endsequence
  sequence seq_answered;
    ##[46:49] o_data_bus_pos_oe;
  endsequence
  sequence seq_packet;
    o_data_bus_pos_oe [*8] ##1 o_data_bus_pos_oe [*8];
  endsequence
  chk_neg_mirror: assert property (o_data_bus_neg == ~o_data_bus_pos)
    else $error("negative data is not the complement");
  chk_oe_pair: assert property (o_data_bus_neg_oe == o_data_bus_pos_oe)
    else $error("enables differ");
  chk_packet_full: assert property ($rose(o_data_bus_pos_oe) |-> seq_packet)
    else $error("read packet shorter than sixteen words");
  chk_packet_end: assert property ($fell(o_data_bus_pos_oe) |-> beat_ff == 4'h0)
    else $error("read burst not a whole number of packets");
  chk_error_pulse: assert property (o_protocol_error |=> !o_protocol_error)
    else $error("error longer than one cycle");
  chk_error_cause: assert property ($rose(o_protocol_error) |-> age_ff inside {[1:4]})
    else $error("error without a request");
  chk_read_answer: assert property (fall && op == dpt_pkg::OP_READ |-> seq_refused or seq_answered)
    else $error("read neither refused nor answered in time");
  chk_idle_silent: assert property (fall && op == dpt_pkg::OP_NOP |-> !o_protocol_error [*8])
    else $error("idle request flagged");
endmodule
`default_nettype wire

/* tb/dpt_ctrl_model.sv */
// memory controller model: link clock, request words, write data
`timescale 1ns/100ps
`default_nettype none
module dpt_ctrl_model
(
  input  wire logic        i_clk,
  output logic             o_master_clock_pos = 1'b0,
  output logic             o_master_clock_neg = 1'b1,
  output logic      [11:0] o_request_bus      = 12'hfff,
  output logic      [15:0] o_data_bus         = 16'h0000
);
  int           cyc;
  logic [255:0] wsched [int];
  // ========
  // one link cycle of eight system clocks; the clock runs on without a gap between calls
  task automatic link_cycle(input logic [23:0] pkt, input logic wr, input logic [255:0] wdat);
    if (wr)
      wsched[cyc + 3] = wdat;
    for (int j = 0; j < 8; j++)
    begin
      @(negedge i_clk);
      o_master_clock_pos = (j < 4);
      o_master_clock_neg = (j >= 4);
      o_request_bus = ~(j < 4 ? pkt[23:12] : pkt[11:0]);
      if (wsched.exists(cyc))
        o_data_bus = wsched[cyc][j*16 +: 16];
      else if (wsched.exists(cyc - 1))
        o_data_bus = wsched[cyc - 1][(j + 8)*16 +: 16];
      else
        o_data_bus = 16'($urandom); // undriven lines show noise, not a held value
    end
    cyc++;
  endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// bench: random request traffic checked against a behavioural dram model
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic             i_clk = 1'b0;
  logic             i_reset_n = 1'b0;
  wire logic        pos, neg, oe, noe, err;
  wire logic [11:0] rq;
  wire logic [15:0] cdq, dq, dout, dneg;
  int               n_fail, check_count, cyc, wi, k;
  int               last_col = -100;
  int               last_rd = -100;
  int               act_t [8], col_t [8], colq [$];
  bit               open_b [8], row_b [8], wr_b [8];
  bit   [255:0]     core [8][2][2], sense [8][2], wd;
  logic [255:0]     cur, rdq [$];
  logic [23:0]      pkt;
  logic             e, wr;
  logic             err_seen = 1'b0;

  always #5 i_clk = ~i_clk;
  assign dq = oe ? dout : cdq; // the device wins the wire while enabled

  dpt_core dpt_core_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_master_clock_pos(pos),
    .i_master_clock_neg(neg), .i_request_bus(rq), .i_data_bus_pos(dq), .o_data_bus_pos(dout),
    .o_data_bus_pos_oe(oe), .o_data_bus_neg(dneg), .o_data_bus_neg_oe(noe), .o_protocol_error(err));
  dpt_ctrl_model dpt_ctrl_model_inst (.i_clk(i_clk), .o_master_clock_pos(pos),
    .o_master_clock_neg(neg), .o_request_bus(rq), .o_data_bus(cdq));

  // ========
  // compares and the closing task
  task automatic check_err(input logic exp, input logic got);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected protocol_error: expected %0b seen %0b", exp, got);
    end
  endtask
  task automatic check_word(input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected data word: expected %h seen %h", exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ========
  // reference model: returns whether the request is refused
  task automatic model(input logic [23:0] p, output logic ex, output logic w);
    logic [2:0] op, b;
    logic       c;
    op = p[23:21];
    b = p[20:18];
    c = p[0];
    ex = 1'b0;
    w = 1'b0;
    if (op == dpt_pkg::OP_ACTIVATE)
    begin
      ex = open_b[b];
      if (!ex)
      begin
        open_b[b] = 1'b1;
        row_b[b] = c;
        act_t[b] = cyc;
        col_t[b] = -100;
        sense[b] = core[b][c];
      end
    end
    else if (op == dpt_pkg::OP_WRITE || op == dpt_pkg::OP_READ)
    begin
      ex = !open_b[b] || cyc - last_col < dpt_pkg::COLUMN_CYCLE_INTERVAL
        || cyc - act_t[b] < (op == dpt_pkg::OP_WRITE ? dpt_pkg::ACTIVATE_TO_WRITE_DELAY
        : dpt_pkg::ACTIVATE_TO_READ_DELAY);
      if (!ex)
      begin
        last_col = cyc;
        col_t[b] = cyc;
        colq.push_back(cyc);
        if (colq.size() > 3)
          void'(colq.pop_front());
        wr_b[b] = (op == dpt_pkg::OP_WRITE);
        w = wr_b[b];
        if (w)
          sense[b][c] = wd;
        else
        begin
          rdq.push_back(sense[b][c]);
          last_rd = cyc;
        end
      end
    end
    else if (op == dpt_pkg::OP_PRECHARGE && open_b[b])
    begin
      ex = cyc - col_t[b] < (wr_b[b] ? dpt_pkg::WRITE_TO_PRECHARGE_INTERVAL
        : dpt_pkg::READ_TO_PRECHARGE_INTERVAL);
      if (!ex)
      begin
        open_b[b] = 1'b0;
        core[b][row_b[b]] = sense[b];
      end
    end
  endtask

  // ========
  // monitors: error pulses and read packets, sampled mid-cycle
  always @(negedge i_clk)
  begin
    if (err === 1'b1)
      err_seen = 1'b1;
    if (oe === 1'b1)
    begin
      if (wi == 0)
        cur = rdq.size() > 0 ? rdq.pop_front() : 'x;
      check_word(cur[wi*16 +: 16], dout);
      wi = (wi + 1) % 16;
    end
  end

  // random traffic with spare bits filled; a few idle cycles drain the reads
  initial
  begin
    void'($urandom(32'hb0b7));
    repeat (10) @(negedge i_clk);
    i_reset_n = 1'b1;
    repeat (4) @(negedge i_clk);
    for (k = 0; k < 1212; k++)
    begin
      pkt = {3'($urandom_range(5, 0)), 21'($urandom)};
      if (pkt[23:21] > 3'h4 || k >= 1200)
        pkt[23:21] = 3'h0;
      if (pkt[23:22] == 2'h1 && colq.size() == 3 && cyc - colq[0] <= 8)
        pkt[23:21] = 3'h0; // stay inside four pending columns
      // a read packet and its registered enable still hold the wire up to eight link cycles on, where the data of a write sent up to five cycles later lands
      if (pkt[23:21] == dpt_pkg::OP_WRITE && cyc - last_rd <= 5)
        pkt[23:21] = dpt_pkg::OP_NOP;
      for (int i = 0; i < 8; i++)
        wd[i*32 +: 32] = $urandom;
      model(pkt, e, wr);
      dpt_ctrl_model_inst.link_cycle(pkt, wr, wd);
      // this request's error pulse was caught on the last falling edge; look after it, not beside it
      @(posedge i_clk);
      check_err(e, err_seen);
      err_seen = 1'b0;
      cyc++;
    end
    check_word(16'h0000, 16'(rdq.size()));
    print_verdict;
  end

  // watchdog well past the expected 97 us of traffic; the run is far shorter than one refresh period
  initial
  begin
    #150000;
    n_fail++;
    print_verdict;
  end
endmodule

bind dpt_core dpt_core_monitor dpt_core_monitor_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_master_clock_pos(i_master_clock_pos), .i_master_clock_neg(i_master_clock_neg),
  .i_request_bus(i_request_bus), .i_data_bus_pos(i_data_bus_pos), .o_data_bus_pos(o_data_bus_pos),
  .o_data_bus_pos_oe(o_data_bus_pos_oe), .o_data_bus_neg(o_data_bus_neg),
  .o_data_bus_neg_oe(o_data_bus_neg_oe), .o_protocol_error(o_protocol_error));
`default_nettype wire
